// File: hdl/ecp_pkg.sv
// package of constants and types for the capture/compare/pwm unit
package ecp_pkg;
   // ==========================================================
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] OFF_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_DUTY_HI  = 8'h04;
   localparam logic [7:0] OFF_PERIOD   = 8'h08;
   localparam logic [7:0] OFF_CAPTURE  = 8'h0c;
   localparam logic [7:0] OFF_STATUS   = 8'h10;
   localparam logic [7:0] OFF_PIN_DIR  = 8'h14;
   localparam logic [7:0] OFF_TIMER    = 8'h18;
   // ==========================================================
   // control register fields and reset values
   localparam int OCS_BIT  = 7;
   localparam int DLB_LSB  = 4;
   localparam int MODE_LSB = 0;
   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [7:0]  CONTROL_WMASK = 8'hbf;
   localparam logic [7:0]  DUTY_HI_RST = 8'h00;
   localparam logic [7:0]  PERIOD_RST  = 8'hff;
   localparam logic [1:0]  PIN_DIR_RST = 2'h3;
   localparam logic [3:0]  DEAD_BAND   = 4'h2;
   localparam logic [1:0]  MODE_OFF     = 2'h0;
   localparam logic [1:0]  MODE_CAPTURE = 2'h1;
   localparam logic [1:0]  MODE_COMPARE = 2'h2;
   localparam logic [1:0]  MODE_PWM     = 2'h3;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_WRESP, ST_RRESP} ecp_bus_e;

   typedef struct packed {
      logic       awvalid;
      logic [7:0] awaddr;
      logic       wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic       bready;
      logic       arvalid;
      logic [7:0] araddr;
      logic       rready;
   } ecp_axi_req_s;

   typedef struct packed {
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ecp_axi_rsp_s;
endpackage

// File: hdl/ecp_timer.sv
// free-running 16-bit timer with freeze and clear
`timescale 1ns/100ps
module ecp_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             run,
   input  wire logic             clear,
   output logic [WIDTH-1:0]      count
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (run) begin
         count <= count + WIDTH'(1);
      end
   end
endmodule

// File: hdl/ecp_unit.sv
// capture/compare/pwm unit with axi4-lite register slave
// ==========================================================
// Overview of operation
// R1 - timer one for capture/compare, period timer pwm
// R2 - capture latches timer on input event
// R3 - compare raises output when timer matches
// R4 - pwm period and duty set by software
// R5 - ten-bit duty: high register plus two bits
// R6 - sleep freezes period timer and all state; bus reads and register writes still work in sleep
// R7 - sleep keeps driven pwm pin level
// R8 - after wake period timer resumes, not cleared
// R9 - pwm rate follows system clock
// R10 - reset restores registers, pins to input
// R11 - software enables pin after period overflow
// R12 - pwm: single output or half-bridge dead band
// R13 - mode field selects off/capture/compare/pwm
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module ecp_unit #(
   parameter int TW = 16
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   input  wire logic                 sleep,
   input  wire logic                 event_in,
   input  wire ecp_pkg::ecp_axi_req_s axi_req,
   output ecp_pkg::ecp_axi_rsp_s     axi_rsp,
   output logic                      output_pin_a,
   output logic                      output_pin_a_oe,
   output logic                      output_pin_b,
   output logic                      output_pin_b_oe
);
   typedef struct packed {
      ecp_pkg::ecp_bus_e     bst;
      ecp_pkg::ecp_axi_rsp_s rsp;
      logic [7:0]  control;
      logic [7:0]  duty_hi;
      logic [7:0]  period;
      logic [1:0]  pin_oe;
      logic [TW-1:0] capture;
      logic [TW-1:0] compare;
      logic [9:0]  duty_act;
      logic [9:0]  ptick;
      logic [7:0]  period_timer_count;
      logic        pwm_raw;
      logic [3:0]  db_cnt;
      logic        event_d;
      logic        cap_flag;
      logic        cmp_flag;
      logic        period_timer_flag;
      logic        pa;
      logic        pb;
   } ecp_state_s;

   ecp_state_s s_reg;
   ecp_state_s s_next;
   logic [TW-1:0] capture_timebase;
   logic          run;
   logic [1:0]    mode;
   logic          wr_go;
   logic          rd_go;
   logic [7:0]    waddr;
   logic [31:0]   rd_val;
   logic [9:0]    tick_lim;
   logic          cap_set;
   logic          cmp_set;
   logic          ptf_set;

   assign run  = ce && !sleep; // [R6]
   assign mode = s_reg.control[ecp_pkg::MODE_LSB+2 +: 2]; // [R13]

   // ==========================================================
   // capture/compare timebase
   ecp_timer #(.WIDTH(TW)) u_tb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run),
      .clear   (1'b0),
      .count   (capture_timebase)
   ); // [R1]

   assign wr_go = s_reg.bst == ecp_pkg::ST_IDLE && axi_req.awvalid && axi_req.wvalid;
   assign rd_go = s_reg.bst == ecp_pkg::ST_IDLE && axi_req.arvalid && !wr_go;
   assign waddr = axi_req.awaddr;
   assign tick_lim = {s_reg.period, 2'h3};

   always_comb begin
      rd_val = 32'h0;
      case (axi_req.araddr)
         ecp_pkg::OFF_CONTROL: rd_val = {24'h0, s_reg.control};
         ecp_pkg::OFF_DUTY_HI: rd_val = {24'h0, s_reg.duty_hi};
         ecp_pkg::OFF_PERIOD:  rd_val = {24'h0, s_reg.period};
         ecp_pkg::OFF_CAPTURE: rd_val = {{(32-TW){1'b0}}, s_reg.capture};
         ecp_pkg::OFF_STATUS:  rd_val = {29'h0, s_reg.period_timer_flag,
                                         s_reg.cmp_flag, s_reg.cap_flag};
         ecp_pkg::OFF_PIN_DIR: rd_val = {30'h0, ~s_reg.pin_oe};
         ecp_pkg::OFF_TIMER:   rd_val = {24'h0, s_reg.period_timer_count};
         default:              rd_val = 32'h0;
      endcase
   end

   always_comb begin
      s_next = s_reg;
      cap_set = 1'b0;
      cmp_set = 1'b0;
      ptf_set = 1'b0;
      s_next.rsp.awready = 1'b0;
      s_next.rsp.wready  = 1'b0;
      s_next.rsp.arready = 1'b0;
      // ==========================================================
      // bus slave: write taken with address and data together
      case (s_reg.bst)
         ecp_pkg::ST_IDLE: begin
            if (wr_go) begin
               s_next.rsp.awready = 1'b1;
               s_next.rsp.wready  = 1'b1;
               s_next.rsp.bvalid  = 1'b1;
               s_next.rsp.bresp   = ecp_pkg::RESP_OKAY;
               s_next.bst         = ecp_pkg::ST_WRESP;
               case (waddr)
                  ecp_pkg::OFF_CONTROL:
                     if (axi_req.wstrb[0])
                        s_next.control = axi_req.wdata[7:0] & ecp_pkg::CONTROL_WMASK;
                  ecp_pkg::OFF_DUTY_HI:
                     if (axi_req.wstrb[0]) s_next.duty_hi = axi_req.wdata[7:0];
                  ecp_pkg::OFF_PERIOD:
                     if (axi_req.wstrb[0]) s_next.period = axi_req.wdata[7:0];
                  ecp_pkg::OFF_CAPTURE: begin
                     if (axi_req.wstrb[0]) s_next.compare[7:0] = axi_req.wdata[7:0];
                     if (axi_req.wstrb[1]) s_next.compare[15:8] = axi_req.wdata[15:8];
                  end
                  ecp_pkg::OFF_STATUS: ;
                  ecp_pkg::OFF_PIN_DIR:
                     if (axi_req.wstrb[0]) s_next.pin_oe = ~axi_req.wdata[1:0]; // [R11]
                  ecp_pkg::OFF_TIMER:
                     if (axi_req.wstrb[0]) s_next.period_timer_count = axi_req.wdata[7:0];
                  default: s_next.rsp.bresp = ecp_pkg::RESP_SLVERR;
               endcase
            end else if (rd_go) begin
               s_next.rsp.arready = 1'b1;
               s_next.rsp.rvalid  = 1'b1;
               s_next.rsp.rdata   = rd_val;
               s_next.rsp.rresp   = (axi_req.araddr > ecp_pkg::OFF_TIMER ||
                                     axi_req.araddr[1:0] != 2'h0) ?
                                    ecp_pkg::RESP_SLVERR : ecp_pkg::RESP_OKAY;
               s_next.bst         = ecp_pkg::ST_RRESP;
            end
         end
         ecp_pkg::ST_WRESP:
            if (axi_req.bready) begin
               s_next.rsp.bvalid = 1'b0;
               s_next.bst        = ecp_pkg::ST_IDLE;
            end
         ecp_pkg::ST_RRESP:
            if (axi_req.rready) begin
               s_next.rsp.rvalid = 1'b0;
               s_next.bst        = ecp_pkg::ST_IDLE;
            end
         default: s_next.bst = ecp_pkg::ST_IDLE;
      endcase

      // ==========================================================
      // timer logic, frozen while asleep
      if (!sleep) begin // [R6] [R7] [R8]
         s_next.event_d = event_in;
         case (mode)
            ecp_pkg::MODE_CAPTURE:
               if (event_in && !s_reg.event_d) begin
                  s_next.capture  = capture_timebase; // [R2]
                  s_next.cap_flag = 1'b1;
                  cap_set         = 1'b1;
               end
            ecp_pkg::MODE_COMPARE:
               if (capture_timebase == s_reg.compare) begin
                  s_next.cmp_flag = 1'b1; // [R3]
                  cmp_set         = 1'b1;
                  s_next.pa       = !s_reg.control[ecp_pkg::MODE_LSB];
               end
            ecp_pkg::MODE_PWM: begin
               // quarter-cycle ticks give ten-bit duty resolution off aclk [R9]
               s_next.ptick = s_reg.ptick + 10'h1;
               if (s_reg.ptick[1:0] == 2'h3)
                  s_next.period_timer_count = s_reg.period_timer_count + 8'h1;
               // a period written below the running count ends the period at once
               if (s_reg.ptick >= tick_lim) begin // [R4]
                  s_next.ptick              = 10'h0;
                  s_next.period_timer_count = 8'h0;
                  s_next.period_timer_flag  = 1'b1;
                  ptf_set                   = 1'b1;
                  s_next.duty_act = {s_reg.duty_hi,
                                     s_reg.control[ecp_pkg::DLB_LSB +: 2]}; // [R5]
                  // output high for exactly duty_act ticks; zero duty stays low
                  s_next.pwm_raw  = s_next.duty_act != 10'h0;
               end else if (s_reg.ptick + 10'h1 == s_reg.duty_act) begin
                  s_next.pwm_raw = 1'b0;
               end
               if (s_next.pwm_raw != s_reg.pwm_raw)
                  s_next.db_cnt = ecp_pkg::DEAD_BAND;
               else if (s_reg.db_cnt != 4'h0)
                  s_next.db_cnt = s_reg.db_cnt - 4'h1;
               if (s_reg.control[ecp_pkg::OCS_BIT]) begin // [R12]
                  s_next.pa = s_reg.pwm_raw && s_reg.db_cnt == 4'h0;
                  s_next.pb = !s_reg.pwm_raw && s_reg.db_cnt == 4'h0;
               end else begin
                  s_next.pa = s_reg.pwm_raw;
                  s_next.pb = 1'b0;
               end
            end
            default: begin
               s_next.pa = 1'b0;
               s_next.pb = 1'b0;
            end
         endcase
      end
      // status flags clear on write of one; a new event wins
      if (wr_go && waddr == ecp_pkg::OFF_STATUS && axi_req.wstrb[0]) begin
         if (axi_req.wdata[0] && !cap_set)
            s_next.cap_flag = 1'b0;
         if (axi_req.wdata[1] && !cmp_set)
            s_next.cmp_flag = 1'b0;
         if (axi_req.wdata[2] && !ptf_set)
            s_next.period_timer_flag = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin // [R10]
         s_reg         <= '0;
         s_reg.control <= ecp_pkg::CONTROL_RST;
         s_reg.duty_hi <= ecp_pkg::DUTY_HI_RST;
         s_reg.period  <= ecp_pkg::PERIOD_RST;
         s_reg.pin_oe  <= ~ecp_pkg::PIN_DIR_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign axi_rsp = s_reg.rsp;
   // pin_oe holds the inverse of the software direction bits, so enables leave a flop
   assign output_pin_a    = s_reg.pa;
   assign output_pin_a_oe = s_reg.pin_oe[0];
   assign output_pin_b    = s_reg.pb;
   assign output_pin_b_oe = s_reg.pin_oe[1];
endmodule

// File: tb/ecp_pins_model.sv
// pin load and event source standing outside the capture/compare/pwm unit
`timescale 1ns/100ps
module ecp_pins_model (
   input  wire logic aclk,
   input  wire logic fire,
   input  wire logic pin_a,
   input  wire logic pin_a_oe,
   output logic      event_in,
   output logic      pad_a
);
   // ==========================================================
   // pad with pull-down while released, event line from the bench
   assign pad_a = pin_a_oe ? pin_a : 1'b0;
   always_ff @(posedge aclk) event_in <= fire;
endmodule

// File: tb/ecp_unit_chk.sv
// port assertions for the capture/compare/pwm unit
`timescale 1ns/100ps
module ecp_unit_chk (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   input wire logic                  sleep,
   input wire ecp_pkg::ecp_axi_req_s axi_req,
   input wire ecp_pkg::ecp_axi_rsp_s axi_rsp,
   input wire logic                  output_pin_a,
   input wire logic                  output_pin_a_oe,
   input wire logic                  output_pin_b,
   input wire logic                  output_pin_b_oe
);
   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd_done;
      $rose(axi_rsp.rvalid);
   endsequence
   reset_state_a: assert property (disable iff (1'b0) !aresetn |=>
      !output_pin_a_oe && !output_pin_b_oe && !axi_rsp.bvalid) else $error("reset state");
   sleep_hold_a: assert property (sleep && $past(sleep) |-> $stable(output_pin_a) &&
      $stable(output_pin_b) && $stable(output_pin_a_oe)) else $error("pin moved in sleep");
   clk_freeze_a: assert property (!ce && aresetn |=> $stable(axi_rsp) &&
      $stable(output_pin_a)) else $error("state moved without clock enable");
   wr_cause_a: assert property ($rose(axi_rsp.bvalid) |->
      $past(axi_req.awvalid && axi_req.wvalid)) else $error("write answer without request");
   rd_cause_a: assert property (s_rd_done |-> $past(axi_req.arvalid))
      else $error("read answer without request");
   ready_pulse_a: assert property (axi_rsp.awready && ce |=> !axi_rsp.awready)
      else $error("awready longer than one cycle");
   bad_addr_a: assert property (s_rd_done and $past(axi_req.araddr) == 8'h1c |->
      axi_rsp.rresp == ecp_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("no slverr");
   ctl_bit6_a: assert property (s_rd_done and $past(axi_req.araddr) == 8'h00 |->
      !axi_rsp.rdata[6]) else $error("unused control bit set");
endmodule
bind ecp_unit ecp_unit_chk u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sleep(sleep),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .output_pin_a(output_pin_a),
   .output_pin_a_oe(output_pin_a_oe), .output_pin_b(output_pin_b),
   .output_pin_b_oe(output_pin_b_oe));

// File: tb/enhanced_capture_compare_pwm_test.sv
// register-level tests of the capture/compare/pwm unit
`timescale 1ns/100ps
module enhanced_capture_compare_pwm_test;
   logic                  aclk, aresetn, ce, sleep, fire, event_in, pad_a;
   logic                  pin_a, pin_a_oe, pin_b, pin_b_oe;
   ecp_pkg::ecp_axi_req_s axi_req;
   ecp_pkg::ecp_axi_rsp_s axi_rsp;
   logic [31:0]           q, t0, k;
   logic [1:0]            r;
   int                    fails, check_count, n;
   ecp_unit i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sleep(sleep),
      .event_in(event_in), .axi_req(axi_req), .axi_rsp(axi_rsp), .output_pin_a(pin_a),
      .output_pin_a_oe(pin_a_oe), .output_pin_b(pin_b), .output_pin_b_oe(pin_b_oe));
   ecp_pins_model i_pins (.aclk(aclk), .fire(fire), .pin_a(pin_a), .pin_a_oe(pin_a_oe),
      .event_in(event_in), .pad_a(pad_a));
   // ==========================================================
   // bus and compare tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge aclk);
      axi_req <= '{awvalid: w, awaddr: a, wvalid: w, wdata: d, wstrb: 4'hf, bready: w,
                   arvalid: !w, araddr: a, rready: !w};
      do @(posedge aclk);
      while ((w ? axi_rsp.bvalid : axi_rsp.rvalid) !== 1'b1 && ++c < 200);
      if (c >= 200) fails++;
      q = axi_rsp.rdata;
      r = w ? axi_rsp.bresp : axi_rsp.rresp;
      axi_req <= '0;
   endtask
   task automatic rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      cmp(q & m, e);
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // clock, watchdog and tests
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (100000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end
   initial begin
      aresetn = 1'b0; ce = 1'b1; sleep = 1'b0; fire = 1'b0; axi_req = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      cmp({pin_b_oe, pin_a_oe}, 32'h0);
      rm(ecp_pkg::OFF_CONTROL, 32'hff, 32'h00);
      rm(ecp_pkg::OFF_PERIOD, 32'hff, 32'hff);
      rm(ecp_pkg::OFF_PIN_DIR, 32'h3, 32'h3);
      xfer(1'b1, ecp_pkg::OFF_CONTROL, 32'hff);
      rm(ecp_pkg::OFF_CONTROL, 32'hff, 32'hbf);
      rm(8'h1c, 32'hffffffff, 32'h0);
      cmp({30'h0, r}, {30'h0, ecp_pkg::RESP_SLVERR});
      xfer(1'b1, ecp_pkg::OFF_CONTROL, 32'h04);
      fire <= 1'b1;
      t0 = 32'($time);
      repeat (3) @(posedge aclk);
      fire <= 1'b0;
      rm(ecp_pkg::OFF_STATUS, 32'h1, 32'h1);
      xfer(1'b0, ecp_pkg::OFF_CAPTURE, 32'h0);
      k = q;
      xfer(1'b1, ecp_pkg::OFF_STATUS, 32'h1);
      rm(ecp_pkg::OFF_STATUS, 32'h1, 32'h0);
      // second event at the same phase: captures differ by the elapsed cycles
      fire <= 1'b1;
      t0 = 32'($time) - t0;
      repeat (3) @(posedge aclk);
      fire <= 1'b0;
      rm(ecp_pkg::OFF_CAPTURE, 32'hffff, (k + t0 / 32'd10) & 32'hffff);
      xfer(1'b1, ecp_pkg::OFF_CONTROL, 32'h08);
      xfer(1'b1, ecp_pkg::OFF_CAPTURE, q + 32'h100);
      xfer(1'b1, ecp_pkg::OFF_PIN_DIR, 32'h0);
      for (n = 0; n < 70000 && pad_a !== 1'b1; n++) @(posedge aclk);
      cmp(pad_a, 32'h1);
      rm(ecp_pkg::OFF_STATUS, 32'h2, 32'h2);
      xfer(1'b1, ecp_pkg::OFF_PIN_DIR, 32'h3);
      xfer(1'b1, ecp_pkg::OFF_PERIOD, 32'h3);
      for (int lb = 0; lb < 2; lb++) begin
         xfer(1'b1, ecp_pkg::OFF_DUTY_HI, 32'h2);
         xfer(1'b1, ecp_pkg::OFF_CONTROL, 32'h0c | (lb << 4));
         xfer(1'b1, ecp_pkg::OFF_STATUS, 32'h4);
         for (n = 0; n < 40; n++) begin
            xfer(1'b0, ecp_pkg::OFF_STATUS, 32'h0);
            if (q[2] === 1'b1) break;
         end
         cmp(q & 32'h4, 32'h4);
         xfer(1'b1, ecp_pkg::OFF_PIN_DIR, 32'h0);
         repeat (32) @(posedge aclk);
         k = 0;
         repeat (16) @(posedge aclk) k += pad_a;
         cmp(k, 32'd8 + lb);
      end
      // half-bridge, duty 8 of 16: each pin loses the dead band
      xfer(1'b1, ecp_pkg::OFF_CONTROL, 32'h8c);
      repeat (32) @(posedge aclk);
      k = 0;
      t0 = 0;
      repeat (16) @(posedge aclk) begin
         k += pad_a;
         t0 += pin_b & pin_b_oe;
      end
      cmp(k, 32'd8 - 32'(ecp_pkg::DEAD_BAND));
      cmp(t0, 32'd8 - 32'(ecp_pkg::DEAD_BAND));
      sleep <= 1'b1;
      xfer(1'b0, ecp_pkg::OFF_TIMER, 32'h0);
      t0 = q;
      ce <= 1'b0;
      repeat (4) @(posedge aclk);
      ce <= 1'b1;
      repeat (20) @(posedge aclk);
      rm(ecp_pkg::OFF_TIMER, 32'hffffffff, t0);
      sleep <= 1'b0;
      tally_and_finish();
   end
endmodule
